// ===== hdl/lds_pkg.sv
// Shared constants, types and helpers for lane deskew and inversion
package lds_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int DEF_LANES        = 10;
  localparam int SAMPLES_PER_ELEM = 4;
  localparam int ELEM_BITS        = 5;
  localparam logic [2:0] PARITY_SLOT = 3'h4;
  localparam int ELEM_DBL         = 2 * ELEM_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // Skew budgets and timing
  localparam int TIGHT_SKEW_PS    = 600;
  localparam int RELAXED_SKEW_PS  = 1500;
  localparam int CLK_PERIOD_NS    = 50;
  localparam int DEF_UI_PS        = CLK_PERIOD_NS * 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Lock thresholds
  localparam int LOCK_MATCHES     = 8;
  localparam int UNLOCK_MISSES    = 4;
  localparam int LOSS_ELEMS       = 4;
  localparam int CNT_W            = 4;

  typedef enum logic [1:0] {
    FRM_HUNT,
    FRM_CHECK,
    FRM_SYNC
  } lds_frm_e;

  // Whole unit intervals covering a skew, at least one
  function automatic int skew_taps(input int skew_ps, input int ui_ps);
    int t;
    t = (skew_ps + ui_ps - 1) / ui_ps;
    return (t < 1) ? 1 : t;
  endfunction

endpackage

// ===== hdl/lds_link_if.sv
// Link between the deskew source and sink: data lanes plus reference lane
`timescale 1ns/1ps
interface lds_link_if #(
  parameter int N = lds_pkg::DEF_LANES
);
  logic [N-1:0] rx_lane_bits;
  logic         rx_reference_lane;

  modport src (
    output rx_lane_bits,
    output rx_reference_lane
  );

  modport snk (
    input  rx_lane_bits,
    input  rx_reference_lane
  );
endinterface

// ===== hdl/lds_source.sv
// Deskew source: stripes user lanes and builds the reference lane frame
`timescale 1ns/1ps
module lds_source #(
  parameter int N = lds_pkg::DEF_LANES
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [N-1:0] i_lane_bits,
  input  wire logic         i_invert_en,
  lds_link_if.src           link
);

  localparam int ELEMS = 2 * N + 1;
  localparam int EW    = $clog2(ELEMS);
  localparam int LW    = $clog2(N);
  localparam logic [EW-1:0] LAST_ELEM = EW'(ELEMS - 1);
  localparam logic [LW-1:0] TOP_LANE  = LW'(N - 1);

  generate
    if (N < 2) begin : g_chk
      $error("lds_source needs at least two lanes");
    end
  endgenerate

  logic [2:0]    slot;
  logic [EW-1:0] elem;
  logic [LW-1:0] lane_idx;
  logic          acc;
  logic          odd_elem;
  logic [N-1:0]  tx_bits;
  logic          sample;

  ////////////////////////////////////////////////////////////////////////////
  // Inversion over the five bit times of odd elements
  always_comb begin
    odd_elem = elem[0];
    tx_bits  = i_lane_bits ^ {N{i_invert_en & odd_elem}};
    sample   = tx_bits[lane_idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame position: elements of four samples plus parity
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      slot     <= 3'h0;
      elem     <= '0;
      lane_idx <= TOP_LANE;
    end else if (slot == lds_pkg::PARITY_SLOT) begin
      slot <= 3'h0;
      if (elem == LAST_ELEM) begin
        elem     <= '0;
        lane_idx <= TOP_LANE;
      end else begin
        elem <= elem + EW'(1);
      end
    end else begin
      slot     <= slot + 3'h1;
      lane_idx <= (lane_idx == '0) ? TOP_LANE : lane_idx - LW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parity accumulation and lane outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      acc                    <= 1'b0;
      link.rx_lane_bits      <= '0;
      link.rx_reference_lane <= 1'b0;
    end else begin
      link.rx_lane_bits <= tx_bits;
      if (slot == lds_pkg::PARITY_SLOT) begin
        acc                    <= 1'b0;
        link.rx_reference_lane <= acc ^ odd_elem;
      end else begin
        acc                    <= (slot == 3'h0) ? sample : acc ^ sample;
        link.rx_reference_lane <= sample;
      end
    end
  end

endmodule

// ===== hdl/lds_sink.sv
// Deskew sink: frames the reference lane, aligns lanes, re-inverts data
`timescale 1ns/1ps
module lds_sink #(
  parameter int N       = lds_pkg::DEF_LANES,
  parameter bit RELAXED = 1'b1,
  parameter int UI_PS   = lds_pkg::DEF_UI_PS
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  lds_link_if.snk           link,
  input  wire logic         i_invert_en,
  output logic [N-1:0]      o_lane_bits,
  output logic [N-1:0]      o_lane_locked,
  output logic              o_frame_locked,
  output logic              o_lane_misalign_alarm,
  output logic              o_mismatch
);

  localparam int SKEW_PS = RELAXED ? lds_pkg::RELAXED_SKEW_PS
                                   : lds_pkg::TIGHT_SKEW_PS;
  localparam int REF_DLY = lds_pkg::skew_taps(SKEW_PS, UI_PS);
  localparam int TAPS    = 2 * REF_DLY + 1;
  localparam int SW      = $clog2(TAPS);
  localparam int ELEMS   = 2 * N + 1;
  localparam int EW      = $clog2(ELEMS);
  localparam int LW      = $clog2(N);
  localparam int CW      = lds_pkg::CNT_W;
  localparam logic [EW-1:0] LAST_ELEM = EW'(ELEMS - 1);
  localparam logic [LW-1:0] TOP_LANE  = LW'(N - 1);
  localparam int SPE = lds_pkg::SAMPLES_PER_ELEM;
  localparam logic [LW-1:0] RESUME_LANE = LW'((2 * N - 1 - (SPE % N)) % N);
  localparam logic [SW-1:0] LAST_TAP  = SW'(TAPS - 1);
  localparam logic [CW-1:0] LOCK_END  = CW'(lds_pkg::LOCK_MATCHES - 1);
  localparam logic [CW-1:0] MISS_END  = CW'(lds_pkg::UNLOCK_MISSES - 1);
  localparam logic [CW-1:0] LOSS_END  = CW'(lds_pkg::LOSS_ELEMS - 1);
  localparam int ED = lds_pkg::ELEM_DBL;
  localparam int EB = lds_pkg::ELEM_BITS;

  generate
    if (N < 2 || UI_PS < 1) begin : g_chk
      $error("lds_sink needs two or more lanes and a positive UI");
    end
  endgenerate

  lds_pkg::lds_frm_e state;
  logic [REF_DLY:0]  ref_hist;
  logic              ref_bit;
  logic [ED-2:0]     win;
  logic [ED-1:0]     cur;
  logic              cand;
  logic [2:0]        slot;
  logic [EW-1:0]     elem;
  logic [LW-1:0]     lane_idx;
  logic              acc;
  logic              par_ok;
  logic              elem_end;
  logic [CW-1:0]     bad_cnt;
  logic              in_sync;
  logic              inv_now;
  logic [N-1:0]      err;
  logic [TAPS-1:0]   hist [N];

  ////////////////////////////////////////////////////////////////////////////
  // Reference lane delay and framing window
  always_comb begin
    ref_bit  = ref_hist[REF_DLY];
    cur      = {win, ref_bit};
    cand     = ~(^cur[EB-1:0]) & ~(^cur[ED-1:EB]);
    elem_end = (slot == lds_pkg::PARITY_SLOT);
    par_ok   = ((acc ^ ref_bit) == elem[0]);
    in_sync  = (state == lds_pkg::FRM_SYNC);
    inv_now  = i_invert_en & in_sync & elem[0];
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ref_hist <= '0;
      win      <= '0;
    end else begin
      ref_hist <= {ref_hist[REF_DLY-1:0], link.rx_reference_lane};
      win      <= cur[ED-2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame position counters
  always_ff @(posedge i_clk) begin
    if (i_reset || state == lds_pkg::FRM_HUNT) begin
      // Hunt hit ends element 0; resume at element 1
      slot     <= 3'h0;
      elem     <= EW'(1);
      lane_idx <= RESUME_LANE;
      acc      <= 1'b0;
    end else if (elem_end) begin
      slot <= 3'h0;
      acc  <= 1'b0;
      if (elem == LAST_ELEM) begin
        elem     <= '0;
        lane_idx <= TOP_LANE;
      end else begin
        elem <= elem + EW'(1);
      end
    end else begin
      slot     <= slot + 3'h1;
      acc      <= (slot == 3'h0) ? ref_bit : acc ^ ref_bit;
      lane_idx <= (lane_idx == '0) ? TOP_LANE : lane_idx - LW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference frame hunt, check and sync
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state   <= lds_pkg::FRM_HUNT;
      bad_cnt <= '0;
    end else begin
      case (state)
        lds_pkg::FRM_HUNT: begin
          bad_cnt <= '0;
          if (cand) begin
            state <= lds_pkg::FRM_CHECK;
          end
        end
        lds_pkg::FRM_CHECK: begin
          if (elem_end && !par_ok) begin
            state <= lds_pkg::FRM_HUNT;
          end else if (elem_end && elem == LAST_ELEM) begin
            state <= lds_pkg::FRM_SYNC;
          end
        end
        lds_pkg::FRM_SYNC: begin
          if (elem_end) begin
            if (par_ok) begin
              bad_cnt <= '0;
            end else if (bad_cnt == LOSS_END) begin
              state <= lds_pkg::FRM_HUNT;
            end else begin
              bad_cnt <= bad_cnt + CW'(1);
            end
          end
        end
        default: begin
          state <= lds_pkg::FRM_HUNT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane delay search, lock and aligned output
  genvar l;
  generate
    for (l = 0; l < N; l++) begin : g_lane
      logic [SW-1:0] sel;
      logic [CW-1:0] cnt;
      logic          tap;
      logic          hit;
      logic          match;

      always_comb begin
        tap    = hist[l][sel];
        hit    = in_sync & ~elem_end & (lane_idx == LW'(l));
        match  = (tap == ref_bit);
        err[l] = hit & ~match;
      end

      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          hist[l] <= '0;
        end else begin
          hist[l] <= {hist[l][TAPS-2:0], link.rx_lane_bits[l]};
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_reset || state == lds_pkg::FRM_HUNT) begin
          sel              <= '0;
          cnt              <= '0;
          o_lane_locked[l] <= 1'b0;
        end else if (hit && !o_lane_locked[l]) begin
          if (!match) begin
            sel <= (sel == LAST_TAP) ? '0 : sel + SW'(1);
            cnt <= '0;
          end else if (cnt == LOCK_END) begin
            o_lane_locked[l] <= 1'b1;
            cnt              <= '0;
          end else begin
            cnt <= cnt + CW'(1);
          end
        end else if (hit) begin
          if (match) begin
            cnt <= '0;
          end else if (cnt == MISS_END) begin
            o_lane_locked[l] <= 1'b0;
            cnt              <= '0;
          end else begin
            cnt <= cnt + CW'(1);
          end
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          o_lane_bits[l] <= 1'b0;
        end else begin
          o_lane_bits[l] <= tap ^ inv_now;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Alarm and error reporting
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_lane_misalign_alarm <= 1'b1;
      o_frame_locked        <= 1'b0;
      o_mismatch            <= 1'b0;
    end else begin
      o_lane_misalign_alarm <= ~(in_sync & (&o_lane_locked));
      o_frame_locked        <= in_sync;
      o_mismatch            <= |err;
    end
  end

endmodule

// ===== bench/lds_props.sv
// Concurrent checks on the deskew link and the sink status outputs
`timescale 1ns/1ps
module lds_props #(
  parameter int N = lds_pkg::DEF_LANES
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [N-1:0] rx_lane_bits,
  input  wire logic         rx_reference_lane,
  input  wire logic [N-1:0] i_lane_bits,
  input  wire logic         i_invert_en,
  input  wire logic [N-1:0] o_lane_locked,
  input  wire logic         o_frame_locked,
  input  wire logic         o_lane_misalign_alarm
);
  logic       run;
  logic [2:0] slot;
  int         elem;
  int         samp;
  logic       acc;

  ////////////////////////////////////////////////////////////////////////////
  // Frame position tracker
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      run  <= 1'b0;
      slot <= 3'h0;
      elem <= 0;
      samp <= 0;
      acc  <= 1'b0;
    end else begin
      run <= 1'b1;
      if (run && slot == lds_pkg::PARITY_SLOT) begin
        slot <= 3'h0;
        acc  <= 1'b0;
        elem <= (elem == 2 * N) ? 0 : elem + 1;
        if (elem == 2 * N)
          samp <= 0;
      end else if (run) begin
        slot <= slot + 3'h1;
        acc  <= acc ^ rx_reference_lane;
        samp <= (samp == N - 1) ? 0 : samp + 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_all_locked;
    (&o_lane_locked) && o_frame_locked;
  endsequence

  a_ref_copies_lane: assert property (
    run && slot != lds_pkg::PARITY_SLOT
      |-> rx_reference_lane == rx_lane_bits[N-1-samp])
    else $error("reference bit differs from lane");
  a_element_parity: assert property (
    run && slot == lds_pkg::PARITY_SLOT
      |-> (acc ^ rx_reference_lane) == elem[0])
    else $error("bad element parity");
  a_odd_inversion: assert property (
    run |-> rx_lane_bits ==
      ($past(i_lane_bits) ^ {N{$past(i_invert_en) && elem[0]}}))
    else $error("lane data inversion wrong");
  a_start_alarmed: assert property (
    $fell(i_reset) |-> o_lane_misalign_alarm && !o_frame_locked
      && o_lane_locked == '0)
    else $error("sink not alarmed after reset");
  a_unlock_alarm: assert property (
    !((&o_lane_locked) && o_frame_locked) |=> o_lane_misalign_alarm)
    else $error("alarm low without full lock");
  a_fall_needs_lock: assert property (
    $fell(o_lane_misalign_alarm)
      |-> $past(&o_lane_locked) && $past(o_frame_locked))
    else $error("alarm cleared without lock");
  a_drop_alarm: assert property (
    |($past(o_lane_locked) & ~o_lane_locked) |=> o_lane_misalign_alarm)
    else $error("lost lane did not raise alarm");
  a_lock_holds: assert property (
    s_all_locked ##1 s_all_locked |-> !o_lane_misalign_alarm)
    else $error("alarm high while locked");
endmodule

// ===== bench/tb_lane_deskew_and_inversion.sv
// Testbench: deskew source and sink joined over the link
`timescale 1ns/1ps
module tb_lane_deskew_and_inversion;
  localparam int N = 10;
  logic         i_clk       = 1'b0;
  logic         i_reset     = 1'b1;
  logic         inv         = 1'b0;
  logic [N-1:0] data        = 10'h2A5;
  logic [N-1:0] out_bits;
  logic [N-1:0] locked;
  logic         frm;
  logic         alarm;
  logic         mism;
  int           n_errors    = 0;
  int           comparisons = 0;

  lds_link_if #(.N(N)) link ();
  lds_source #(.N(N)) lds_source_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_lane_bits(data), .i_invert_en(inv), .link(link));
  lds_sink #(.N(N)) lds_sink_inst (.i_clk(i_clk), .i_reset(i_reset),
    .link(link), .i_invert_en(inv), .o_lane_bits(out_bits),
    .o_lane_locked(locked), .o_frame_locked(frm),
    .o_lane_misalign_alarm(alarm), .o_mismatch(mism));
  lds_props #(.N(N)) lds_props_inst (.i_clk(i_clk), .i_reset(i_reset),
    .rx_lane_bits(link.rx_lane_bits),
    .rx_reference_lane(link.rx_reference_lane),
    .i_lane_bits(data), .i_invert_en(inv), .o_lane_locked(locked),
    .o_frame_locked(frm), .o_lane_misalign_alarm(alarm));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and pseudo-random lane data
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    data <= {data[N-2:0], data[N-1] ^ data[6]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check_bits(input logic [N-1:0] got, input logic [N-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("%0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_lock(input logic en);
    int c;
    @(posedge i_clk);
    i_reset <= 1'b1;
    inv     <= en;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    check_flag(alarm, 1'b1);
    check_bits(locked, '0);
    c = 0;
    while (alarm !== 1'b0 && c < 5000) begin
      @(negedge i_clk);
      c++;
    end
    if (c == 5000) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, alarm, 0);
      conclude();
    end else begin
      check_bits(locked, '1);
      check_flag(frm, 1'b1);
      $display("lock test done, invert %0d", en);
    end
  endtask

  task automatic test_data(input logic en);
    logic [N-1:0] h [5];
    for (int i = 0; i < 400; i++) begin
      @(negedge i_clk);
      for (int j = 4; j > 0; j--)
        h[j] = h[j-1];
      h[0] = data;
      if (i >= 4) begin
        check_bits(out_bits, h[4]);
        check_flag(mism, 1'b0);
        check_flag(alarm, 1'b0);
      end
    end
    $display("data test done, invert %0d", en);
  endtask

  initial begin
    for (int k = 0; k < 2; k++) begin
      test_lock(k[0]);
      test_data(k[0]);
    end
    conclude();
  end
endmodule
